// file: verilog/self_polling_timer_wakeup.v
// Purpose: Polling timer and wake-up decision for autonomous self polling
// Assumes: Configuration ports are static while polling; rssi from same clock
// Notes: On/Off counters advance once per reference tick, period counter once per master period
// Notes on behaviour
// RULE1: Strong signal leaves polling for run state
// RULE2: Reference timer divides clk/64 by divider
// RULE3: Fixed On per config, shared Off time
// RULE4: Single configuration polls only configuration A
// RULE5: Multi configuration cycles up to four
// RULE6: On time applied to each channel
// RULE7: Window end wakes above threshold and upper
// RULE8: No wake keeps peak tracking running
// RULE9: On end wakes outside band above threshold
// RULE10: Wake freezes peak, enters run state
// RULE11: Idle selection skips some polling periods
// RULE12: M active periods then N idle
// RULE13: Reference, on-off, period timers plus FSM
// RULE14: Polling starts when mode select set
// RULE15: At most three channels per configuration
// RULE16: Timeout or end of message restarts On
// RULE17: Reference tick single cycle, then reload
// RULE18: Peak cleared at each On start
`timescale 1ns/1ps
`include "poll_timer_regs.vh"
module self_polling_timer_wakeup #(
   parameter TW = `TIME_W,
   parameter RW = `RSSI_W
)(
   clk,
   reset,
   polling_mode_select,
   multi_config_enable,
   config_count,
   polling_reference_divider,
   on_time_cfg_a_low,
   on_time_cfg_a_high,
   on_time_cfg_b_low,
   on_time_cfg_b_high,
   on_time_cfg_c_low,
   on_time_cfg_c_high,
   on_time_cfg_d_low,
   on_time_cfg_d_high,
   off_time_low,
   off_time_high,
   channel_config_a,
   channel_config_b,
   channel_config_c,
   channel_config_d,
   observation_window,
   wake_strength_threshold,
   wake_band_upper_limit,
   wake_band_lower_limit,
   active_idle_enable,
   active_period_count,
   idle_period_count,
   rssi_sample,
   timeout_event,
   end_of_message_event,
   self_polling_state,
   run_after_polling,
   receiver_on,
   active_config,
   active_channel,
   wake_signal_peak,
   wake_pulse
);
   input wire clk;
   input wire reset;
   input wire polling_mode_select;
   input wire multi_config_enable;
   input wire [1:0] config_count;
   input wire [7:0] polling_reference_divider;
   input wire [7:0] on_time_cfg_a_low;
   input wire [7:0] on_time_cfg_a_high;
   input wire [7:0] on_time_cfg_b_low;
   input wire [7:0] on_time_cfg_b_high;
   input wire [7:0] on_time_cfg_c_low;
   input wire [7:0] on_time_cfg_c_high;
   input wire [7:0] on_time_cfg_d_low;
   input wire [7:0] on_time_cfg_d_high;
   input wire [7:0] off_time_low;
   input wire [7:0] off_time_high;
   input wire [1:0] channel_config_a;
   input wire [1:0] channel_config_b;
   input wire [1:0] channel_config_c;
   input wire [1:0] channel_config_d;
   input wire [TW-1:0] observation_window;
   input wire [RW-1:0] wake_strength_threshold;
   input wire [RW-1:0] wake_band_upper_limit;
   input wire [RW-1:0] wake_band_lower_limit;
   input wire active_idle_enable;
   input wire [7:0] active_period_count;
   input wire [7:0] idle_period_count;
   input wire [RW-1:0] rssi_sample;
   input wire timeout_event;
   input wire end_of_message_event;
   output wire self_polling_state;
   output wire run_after_polling;
   output wire receiver_on;
   output reg [1:0] active_config;
   output reg [1:0] active_channel;
   output reg [RW-1:0] wake_signal_peak;
   output reg wake_pulse;

   reg [2:0] state_q;
   reg [TW-1:0] time_q;
   reg [TW-1:0] win_q;
   reg [RW-1:0] peak_q;
   reg [7:0] period_q;
   reg idle_phase_q;
   wire pre_tick;
   wire ref_tick;
   reg [TW-1:0] on_time;
   reg [1:0] ch_cfg;
   wire [1:0] ch_last;
   wire [1:0] cfg_last;
   wire [TW-1:0] off_time;
   wire [RW-1:0] peak_now;
   wire win_end;
   wire on_end;
   wire wake_win;
   wire wake_end;
   wire [TW-1:0] one_t;
   localparam [2:0] ST_IDLE = 3'h0, ST_ON = 3'h1, ST_OFF = 3'h2, ST_SKIP = 3'h3, ST_RUN = 3'h4; // Control states

   assign one_t = {{(TW-1){1'b0}}, 1'b1};
   assign off_time = {off_time_high, off_time_low};

   // System clock prescaler that enables the reference timer
   tick_divider #(.W(`PRESCALE_W)) u_prescale ( // RULE2
      .clk(clk),
      .reset(reset),
      .en(1'b1),
      .div(`PRESCALE_COUNT),
      .tick(pre_tick)
   );
   // Reference timer, one-cycle tick then reload
   tick_divider #(.W(8)) u_reference ( // RULE13
      .clk(clk),
      .reset(reset),
      .en(pre_tick),
      .div(polling_reference_divider),
      .tick(ref_tick)
   ); // RULE17

   // On time and channel set of the active configuration
   always @*
   begin
      case (active_config)
         2'h0: begin on_time = {on_time_cfg_a_high, on_time_cfg_a_low}; ch_cfg = channel_config_a; end
         2'h1: begin on_time = {on_time_cfg_b_high, on_time_cfg_b_low}; ch_cfg = channel_config_b; end
         2'h2: begin on_time = {on_time_cfg_c_high, on_time_cfg_c_low}; ch_cfg = channel_config_c; end
         default: begin on_time = {on_time_cfg_d_high, on_time_cfg_d_low}; ch_cfg = channel_config_d; end
      endcase // RULE3
   end

   // Channel count limited to three, config count to four
   assign ch_last = (ch_cfg >= `CH_COUNT_MAX) ? 2'h2 : ((ch_cfg == 2'h0) ? 2'h0 : ch_cfg - 2'h1); // RULE15
   assign cfg_last = multi_config_enable ? config_count : `CFG_A; // RULE4 RULE5

   // Peak including current sample
   assign peak_now = (rssi_sample > peak_q) ? rssi_sample : peak_q;
   assign win_end = ref_tick && (win_q + one_t >= observation_window);
   assign on_end = ref_tick && (time_q + one_t >= on_time);
   assign wake_win = (peak_now > wake_strength_threshold) && (peak_now > wake_band_upper_limit); // RULE7
   assign wake_end = (peak_now > wake_strength_threshold) &&
      ((peak_now < wake_band_lower_limit) || (peak_now > wake_band_upper_limit)); // RULE9

   assign self_polling_state = (state_q != ST_IDLE) && (state_q != ST_RUN);
   assign run_after_polling = (state_q == ST_RUN);
   assign receiver_on = (state_q == ST_ON) || (state_q == ST_RUN);

   // Polling control state machine
   always @(posedge clk)
   begin
      if (reset)
      begin
         state_q <= ST_IDLE;
         time_q <= {TW{1'b0}};
         win_q <= {TW{1'b0}};
         peak_q <= {RW{1'b0}};
         period_q <= 8'h00;
         idle_phase_q <= 1'b0;
         active_config <= `CFG_A;
         active_channel <= 2'h0;
         wake_signal_peak <= {RW{1'b0}};
         wake_pulse <= 1'b0;
      end
      else
      begin
         wake_pulse <= 1'b0;
         if (!polling_mode_select)
         begin
            state_q <= ST_IDLE;
         end
         else
         begin
            case (state_q)
               ST_IDLE:
               begin
                  state_q <= ST_ON; // RULE14
                  active_config <= `CFG_A;
                  active_channel <= 2'h0;
                  time_q <= {TW{1'b0}};
                  win_q <= {TW{1'b0}};
                  peak_q <= {RW{1'b0}};
                  period_q <= 8'h00;
                  idle_phase_q <= 1'b0;
               end
               ST_ON:
               begin
                  peak_q <= peak_now; // RULE8
                  if (ref_tick)
                  begin
                     time_q <= time_q + one_t;
                     win_q <= win_end ? {TW{1'b0}} : win_q + one_t;
                  end
                  if ((win_end && wake_win) || (on_end && wake_end))
                  begin
                     wake_signal_peak <= peak_now; // RULE10
                     wake_pulse <= 1'b1;
                     state_q <= ST_RUN; // RULE1
                  end
                  else if (on_end)
                  begin
                     time_q <= {TW{1'b0}};
                     win_q <= {TW{1'b0}};
                     peak_q <= {RW{1'b0}}; // RULE18
                     if (active_channel < ch_last)
                        active_channel <= active_channel + 2'h1; // RULE6
                     else
                     begin
                        active_channel <= 2'h0;
                        if (active_config < cfg_last)
                           active_config <= active_config + 2'h1; // RULE5
                        else
                        begin
                           active_config <= `CFG_A;
                           state_q <= ST_OFF; // RULE3
                        end
                     end
                  end
               end
               ST_OFF, ST_SKIP:
               begin
                  if (ref_tick)
                     time_q <= time_q + one_t;
                  if (ref_tick && (time_q + one_t >= off_time))
                  begin
                     // Master period ended: count active or idle periods
                     time_q <= {TW{1'b0}};
                     if (!active_idle_enable)
                        state_q <= ST_ON; // RULE11
                     else if (!idle_phase_q)
                     begin
                        if (period_q + 8'h01 >= active_period_count)
                        begin
                           period_q <= 8'h00;
                           idle_phase_q <= (idle_period_count != 8'h00);
                           state_q <= (idle_period_count != 8'h00) ? ST_SKIP : ST_ON;
                        end
                        else
                        begin
                           period_q <= period_q + 8'h01;
                           state_q <= ST_ON;
                        end
                     end
                     else if (period_q + 8'h01 >= idle_period_count)
                     begin
                        period_q <= 8'h00;
                        idle_phase_q <= 1'b0;
                        state_q <= ST_ON; // RULE12
                     end
                     else
                     begin
                        period_q <= period_q + 8'h01;
                        state_q <= ST_SKIP; // RULE12
                     end
                  end
               end
               ST_RUN:
               begin
                  if (timeout_event || end_of_message_event)
                  begin
                     state_q <= ST_ON; // RULE16
                     time_q <= {TW{1'b0}};
                     win_q <= {TW{1'b0}};
                     peak_q <= {RW{1'b0}};
                  end
               end
               default:
                  state_q <= ST_IDLE;
            endcase
         end
      end
   end
endmodule // self_polling_timer_wakeup

// file: verilog/poll_timer_regs.vh
// Purpose: Named constants for the self polling timer block
// Assumes: Included by bare name from design files
// Notes: Definitions only
`ifndef POLL_TIMER_REGS_VH
`define POLL_TIMER_REGS_VH
`define PRESCALE_DIV 64
`define PRESCALE_W 7
`define PRESCALE_COUNT 7'h40
`define TIME_W 16
`define RSSI_W 8
`define CFG_A 2'h0
`define CFG_LAST 2'h3
`define CH_COUNT_MAX 2'h3
`endif

// file: verilog/tick_divider.v
// Purpose: Counts enable pulses up to a divider value and emits one tick
// Assumes: Divider value of zero behaves like one
// Notes: Used for the reference timer and the system clock prescaler
`timescale 1ns/1ps
module tick_divider #(
   parameter W = 8
)(
   clk,
   reset,
   en,
   div,
   tick
);
   input wire clk;
   input wire reset;
   input wire en;
   input wire [W-1:0] div;
   output wire tick;
   reg [W-1:0] cnt_q;
   wire last;
   assign last = (cnt_q + {{(W-1){1'b0}}, 1'b1} >= div);
   assign tick = en & last;
   // Count enables, reload on the last one
   always @(posedge clk)
   begin
      if (reset)
         cnt_q <= {W{1'b0}};
      else if (en)
         cnt_q <= last ? {W{1'b0}} : cnt_q + {{(W-1){1'b0}}, 1'b1}; // RULE17
   end
endmodule // tick_divider

// file: testbench/poll_chk.sv
// Purpose: Port assertions for the polling timer
// Assumes: Configuration static while polling
// Notes: Bound into every instance of the timer
`timescale 1ns/1ps
module poll_chk #(
   parameter RW = 8
)(
   input wire clk,
   input wire reset,
   input wire polling_mode_select,
   input wire multi_config_enable,
   input wire timeout_event,
   input wire end_of_message_event,
   input wire [RW-1:0] wake_strength_threshold,
   input wire [RW-1:0] wake_band_upper_limit,
   input wire [RW-1:0] wake_band_lower_limit,
   input wire self_polling_state,
   input wire run_after_polling,
   input wire receiver_on,
   input wire [1:0] active_config,
   input wire [RW-1:0] wake_signal_peak,
   input wire wake_pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Steps of entering an On period and leaving the run state
   sequence s_on; self_polling_state && receiver_on && !run_after_polling; endsequence
   sequence s_evt; run_after_polling && polling_mode_select && (timeout_event || end_of_message_event); endsequence
   property p_start; polling_mode_select && !self_polling_state && !run_after_polling |=> s_on; endproperty
   a_start: assert property (p_start) else $error("no On after select");
   property p_evt; s_evt |=> s_on; endproperty
   a_evt: assert property (p_evt) else $error("no On after event");
   property p_pulse; wake_pulse |-> run_after_polling ##1 !wake_pulse; endproperty
   a_pulse: assert property (p_pulse) else $error("bad wake pulse");
   property p_cause; wake_pulse |-> wake_signal_peak > wake_strength_threshold &&
      (wake_signal_peak > wake_band_upper_limit || wake_signal_peak < wake_band_lower_limit); endproperty
   a_cause: assert property (p_cause) else $error("wake without cause");
   property p_hold; !wake_pulse && !$past(reset) |-> $stable(wake_signal_peak); endproperty
   a_hold: assert property (p_hold) else $error("peak moved");
   property p_stay; run_after_polling && polling_mode_select && !timeout_event && !end_of_message_event
      |=> run_after_polling; endproperty
   a_stay: assert property (p_stay) else $error("run left");
   property p_rose; $rose(run_after_polling) |-> wake_pulse && $past(receiver_on); endproperty
   a_rose: assert property (p_rose) else $error("run without wake");
   property p_single; self_polling_state && !multi_config_enable |-> active_config == 2'h0; endproperty
   a_single: assert property (p_single) else $error("config not A");
endmodule // poll_chk
bind self_polling_timer_wakeup poll_chk #(.RW(RW)) i_poll_chk (.*);

// file: testbench/tb.sv
// Purpose: Self-checking bench for the polling timer
// Assumes: 40 MHz clock, inputs driven at falling edges
// Notes: Strong and sub-threshold signal levels come from a fixed-seed xorshift
`timescale 1ns/1ps
`define CHK(n,e,s) begin comparisons++; if ((s) !== (e)) begin n_errors++; $display("unexpected %s %0h %0h", n, e, s); end end
module tb;
   reg clk, reset, polling_mode_select, multi_config_enable, active_idle_enable, timeout_event, end_of_message_event;
   reg [1:0] config_count, channel_config_a, channel_config_b, channel_config_c, channel_config_d;
   reg [7:0] polling_reference_divider, off_time_low, off_time_high, active_period_count, idle_period_count;
   reg [7:0] on_time_cfg_a_low, on_time_cfg_a_high, on_time_cfg_b_low, on_time_cfg_b_high;
   reg [7:0] on_time_cfg_c_low, on_time_cfg_c_high, on_time_cfg_d_low, on_time_cfg_d_high;
   reg [7:0] wake_strength_threshold, wake_band_upper_limit, wake_band_lower_limit, rssi_sample, v;
   reg [15:0] observation_window;
   reg [31:0] seed;
   reg [3:0] seen, seen_ch;
   wire self_polling_state, run_after_polling, receiver_on, wake_pulse;
   wire [1:0] active_config, active_channel;
   wire [7:0] wake_signal_peak;
   int n_errors, comparisons, cnt, r0, r1, i;
   self_polling_timer_wakeup i_self_polling_timer_wakeup (.*);
   // Clock at 40 MHz
   initial
   begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   // Next xorshift value
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   // Expected On span in clocks
   function int on_cycles(input int d, input int t, input int c);
      on_cycles = 64 * d * t * c;
   endfunction
   // Program timing, then hold reset for 8 clocks
   task cfg(input [7:0] d, input [7:0] t, input [1:0] c, input m);
      begin
         polling_mode_select = 0;
         polling_reference_divider = d;
         {on_time_cfg_a_low, on_time_cfg_b_low, on_time_cfg_c_low, on_time_cfg_d_low} = {4{t}};
         {channel_config_a, channel_config_b, channel_config_c, channel_config_d} = {4{c}};
         multi_config_enable = m;
         reset = 1;
         repeat (8) @(negedge clk);
         reset = 0;
         polling_mode_select = 1;
         @(negedge clk);
         cnt = 0;
      end
   endtask
   // Count clocks while On lasts (k) or until run state
   task hold(input k, input int lim);
      while ((k ? receiver_on : !run_after_polling) && cnt < lim)
      begin
         @(negedge clk);
         cnt++;
      end
   endtask
   // Verdict
   task complete_run;
      begin
         $display("comparisons %0d n_errors %0d", comparisons, n_errors);
         if (n_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // Watchdog
   initial
   begin
      #500000;
      n_errors++;
      complete_run;
   end
   // Main sequence
   initial
   begin
      seed = 32'h64e34eb0;
      {timeout_event, end_of_message_event, config_count, observation_window} = {2'b00, 2'h3, 16'h0001};
      {on_time_cfg_a_high, on_time_cfg_b_high, on_time_cfg_c_high, on_time_cfg_d_high, off_time_high} = 40'h0;
      {off_time_low, active_period_count, idle_period_count} = {8'h01, 8'h01, 8'h01};
      {wake_strength_threshold, wake_band_lower_limit, wake_band_upper_limit} = {8'h40, 8'h50, 8'h90};
      rssi_sample = 8'h00;
      active_idle_enable = 0;
      // Strong level wakes at a window end; event restarts On
      for (i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         v = 8'ha0 | seed[7:0];
         rssi_sample = v;
         cfg(8'h01, 8'h04, 2'h1, 1'b0);
         `CHK("on", 1'b1, self_polling_state & receiver_on)
         hold(0, 200);
         `CHK("window", 1'b1, run_after_polling && cnt <= 130)
         `CHK("peak", v, wake_signal_peak)
         {timeout_event, end_of_message_event} = i[0] ? 2'b01 : 2'b10;
         @(negedge clk);
         {timeout_event, end_of_message_event} = 2'b00;
         `CHK("restart", 1'b1, self_polling_state & receiver_on)
      end
      // In-band level never wakes; On covers three channels
      rssi_sample = 8'h70;
      cfg(8'h02, 8'h02, 2'h3, 1'b0);
      hold(1, 2000);
      `CHK("span", 1'b1, cnt >= on_cycles(2, 2, 3) - 128 && cnt <= on_cycles(2, 2, 3) + 2)
      `CHK("inband", 1'b0, run_after_polling)
      // Below lower limit wakes only at the end of On
      rssi_sample = 8'h48;
      cfg(8'h01, 8'h04, 2'h1, 1'b0);
      hold(0, 400);
      `CHK("late", 1'b1, cnt >= on_cycles(1, 4, 1) - 66 && cnt <= on_cycles(1, 4, 1) + 2)
      `CHK("lowpeak", 8'h48, wake_signal_peak)
      // Configurations visited, single then multi
      for (i = 0; i < 2; i++)
      begin
         seed = xs(seed);
         rssi_sample = seed[7:0] & 8'h3f;
         cfg(8'h01, 8'h01, i[0] ? 2'h3 : 2'h1, i[0]);
         {seen, seen_ch} = 8'h00;
         repeat (800) @(negedge clk) if (receiver_on) {seen[active_config], seen_ch[active_channel]} = 2'b11;
         `CHK("configs", i[0] ? 4'hf : 4'h1, seen)
         `CHK("channels", i[0] ? 4'h7 : 4'h1, seen_ch)
      end
      // On share with and without one idle period per active one
      for (i = 0; i < 2; i++)
      begin
         active_idle_enable = i[0];
         cfg(8'h01, 8'h01, 2'h1, 1'b0);
         repeat (2000) @(negedge clk) cnt += receiver_on;
         if (i[0]) r1 = cnt; else r0 = cnt;
      end
      `CHK("idle", 1'b1, 3 * r1 > 2 * r0 - 200 && 3 * r1 < 2 * r0 + 200)
      complete_run;
   end
endmodule // tb
